// ---- common/lcc_pkg.sv ----
// shared constants and carriers for the cache configuration register bank
package lcc_pkg;

    //////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses on the register port)
    localparam logic [11:0] LCC_OFF_TYPE = 12'h004;
    localparam logic [11:0] LCC_OFF_CTRL = 12'h100;
    localparam logic [11:0] LCC_OFF_AUX = 12'h104;

    //////////////////////////////////////////////////////////////////////////
    // type register field positions
    localparam int LCC_TYPE_CTYPE_HI = 28;
    localparam int LCC_TYPE_CTYPE_LO = 25;
    localparam int LCC_TYPE_H_BIT = 24;
    localparam int LCC_TYPE_DWAY_LO = 20;
    localparam int LCC_TYPE_DASSOC_BIT = 18;
    localparam int LCC_TYPE_DLINE_LO = 12;
    localparam int LCC_TYPE_IWAY_LO = 8;
    localparam int LCC_TYPE_IASSOC_BIT = 6;
    localparam int LCC_TYPE_ILINE_LO = 0;
    localparam logic [1:0] LCC_CTYPE_FIXED = 2'h3;
    localparam logic [1:0] LCC_LINE_32B = 2'h0;
    localparam logic LCC_UNIFIED = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // control and auxiliary field positions and reset values
    localparam int LCC_CTRL_EN_BIT = 0;
    localparam logic [31:0] LCC_CTRL_RESET = 32'h0000_0000;
    localparam int LCC_AUX_WAY_HI = 19;
    localparam int LCC_AUX_WAY_LO = 17;
    localparam int LCC_AUX_ASSOC_BIT = 16;
    localparam int LCC_AUX_RAZ_BIT = 31;
    localparam int LCC_AUX_RAO_BIT = 25;
    localparam logic [31:0] LCC_AUX_RESET = 32'h0202_0000;

    //////////////////////////////////////////////////////////////////////////
    // associativity figures for the capacity product
    localparam logic [4:0] LCC_WAYS_LOW = 5'h08;
    localparam logic [4:0] LCC_WAYS_HIGH = 5'h10;

    //////////////////////////////////////////////////////////////////////////
    // write response codes
    localparam logic [1:0] LCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] LCC_RESP_SLVERR = 2'h2;
    localparam logic [1:0] LCC_RESP_DECERR = 2'h3;

    // register port request
    typedef struct packed {
        logic valid;
        logic write;
        logic secure;
        logic [11:0] addr;
        logic [31:0] wdata;
    } lcc_req_s;

    // register port answer
    typedef struct packed {
        logic valid;
        logic [1:0] code;
        logic [31:0] rdata;
    } lcc_resp_s;

    // sequencer states, gray along idle-sync-update-respond
    typedef enum logic [1:0] {
        LCC_IDLE = 2'b00,
        LCC_SYNC = 2'b01,
        LCC_UPDATE = 2'b11,
        LCC_RESP = 2'b10
    } lcc_state_e;

endpackage : lcc_pkg

// ---- src/lcc_way_decode.sv ----
`timescale 1ns/10ps
// way size decode and total capacity from the auxiliary fields
module lcc_way_decode
    import lcc_pkg::*;
(
    // auxiliary fields
    input wire logic [2:0] way_code,
    input wire logic assoc_sel,
    // decoded figures
    output logic [9:0] way_kb,
    output logic [13:0] total_kb
);

    logic [4:0] ways;

    // reserved code 000 folds onto the smallest size, 111 onto the largest
    always_comb begin
        case (way_code)
            3'h0: way_kb = 10'h010;
            3'h1: way_kb = 10'h010;
            3'h2: way_kb = 10'h020;
            3'h3: way_kb = 10'h040;
            3'h4: way_kb = 10'h080;
            3'h5: way_kb = 10'h100;
            3'h6: way_kb = 10'h200;
            default: way_kb = 10'h200;
        endcase
    end

    // capacity is way size times ways
    assign ways = assoc_sel ? LCC_WAYS_HIGH : LCC_WAYS_LOW;
    assign total_kb = 14'(way_kb * ways);

endmodule : lcc_way_decode

// ---- src/lcc_config_regs.sv ----
`timescale 1ns/10ps
// cache type, main control and auxiliary configuration registers
// Summary of operation
// - type bits 28:25 read 11xy from the two lockdown build options.
// - type register is read only, bit 24 zero, reserved bits zero.
// - auxiliary way size 19:17 copied to type bits 22:20 and 10:8.
// - auxiliary bit 16 copied to type bits 18 and 6.
// - line length code 00 in type bits 13:12 and 1:0.
// - capacity equals reported way size times reported associativity.
// - control readable by anyone, changed only by secure writes.
// - non-secure control write leaves it unchanged, answers DECERR.
// - enable change locks ports, syncs, updates, then answers.
// - control bit 0 enables cache, resets to 0, bits 31:1 zero.
// - non-secure auxiliary write discarded with DECERR, reads open to all.
// - auxiliary write while cache enabled answers SLVERR.
// - DECERR wins over SLVERR on auxiliary writes.
// - way size codes 001..110 decode 16KB..512KB, 000 as 16KB.
module lcc_config_regs
    import lcc_pkg::*;
#(
    parameter bit LOCKDOWN_PER_MASTER_OPTION = 1'b0,
    parameter bit LOCKDOWN_PER_LINE_OPTION = 1'b0
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire lcc_req_s req,
    output logic req_ready,
    output lcc_resp_s resp,
    // cache drain handshake
    output logic ports_locked,
    output logic sync_req,
    input wire logic sync_done,
    // configuration seen by the cache
    output logic cache_enable,
    output logic [31:0] aux_config,
    output logic [9:0] way_size_kb,
    output logic [13:0] cache_size_kb
);

    //////////////////////////////////////////////////////////////////////////
    // state

    lcc_state_e state_r;
    lcc_state_e state_nxt;
    logic ctrl_en_r;
    logic [31:0] auxiliary_config_reg_r;
    logic pend_en_r;
    logic resp_valid_r;
    logic [1:0] resp_code_r;
    logic [31:0] resp_rdata_r;
    logic [31:0] cache_type_info;
    logic [31:0] cache_main_control;
    logic [31:0] aux_view;
    logic take;
    logic hit_type;
    logic hit_ctrl;
    logic hit_aux;
    logic ctrl_accept;
    logic aux_accept;

    //////////////////////////////////////////////////////////////////////////
    // decode

    // requests are taken only while idle
    assign req_ready = (state_r == LCC_IDLE);
    assign take = req.valid && req_ready;
    assign hit_type = (req.addr == LCC_OFF_TYPE);
    assign hit_ctrl = (req.addr == LCC_OFF_CTRL);
    assign hit_aux = (req.addr == LCC_OFF_AUX);
    assign ctrl_accept = take && req.write && hit_ctrl && req.secure;
    assign aux_accept = take && req.write && hit_aux && req.secure && !ctrl_en_r;

    //////////////////////////////////////////////////////////////////////////
    // read views

    // type register assembled from build options and auxiliary fields
    always_comb begin
        cache_type_info = 32'h0000_0000;
        cache_type_info[LCC_TYPE_CTYPE_HI -: 2] = LCC_CTYPE_FIXED;
        cache_type_info[LCC_TYPE_CTYPE_LO + 1] = LOCKDOWN_PER_MASTER_OPTION;
        cache_type_info[LCC_TYPE_CTYPE_LO] = LOCKDOWN_PER_LINE_OPTION;
        cache_type_info[LCC_TYPE_H_BIT] = LCC_UNIFIED;
        cache_type_info[LCC_TYPE_DWAY_LO +: 3] =
            auxiliary_config_reg_r[LCC_AUX_WAY_HI:LCC_AUX_WAY_LO];
        cache_type_info[LCC_TYPE_IWAY_LO +: 3] =
            auxiliary_config_reg_r[LCC_AUX_WAY_HI:LCC_AUX_WAY_LO];
        cache_type_info[LCC_TYPE_DASSOC_BIT] = auxiliary_config_reg_r[LCC_AUX_ASSOC_BIT];
        cache_type_info[LCC_TYPE_IASSOC_BIT] = auxiliary_config_reg_r[LCC_AUX_ASSOC_BIT];
        cache_type_info[LCC_TYPE_DLINE_LO +: 2] = LCC_LINE_32B;
        cache_type_info[LCC_TYPE_ILINE_LO +: 2] = LCC_LINE_32B;
    end

    // control view, only the enable bit is live
    always_comb begin
        cache_main_control = 32'h0000_0000;
        cache_main_control[LCC_CTRL_EN_BIT] = ctrl_en_r;
    end

    // auxiliary view with fixed reserved bits
    always_comb begin
        aux_view = auxiliary_config_reg_r;
        aux_view[LCC_AUX_RAZ_BIT] = 1'b0;
        aux_view[LCC_AUX_RAO_BIT] = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // sequencer for control writes

    // drain, then update, then answer
    always_comb begin
        case (state_r)
            LCC_IDLE: state_nxt = ctrl_accept ? LCC_SYNC : LCC_IDLE;
            LCC_SYNC: state_nxt = sync_done ? LCC_UPDATE : LCC_SYNC;
            LCC_UPDATE: state_nxt = LCC_RESP;
            LCC_RESP: state_nxt = LCC_IDLE;
            default: state_nxt = LCC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= LCC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // value to be written, held during the drain
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend_en_r <= 1'b0;
        end else if (ctrl_accept) begin
            pend_en_r <= req.wdata[LCC_CTRL_EN_BIT];
        end
    end

    // ports stay locked through the update step, sync asserted until drained
    assign ports_locked = (state_r == LCC_SYNC) || (state_r == LCC_UPDATE);
    assign sync_req = (state_r == LCC_SYNC);

    //////////////////////////////////////////////////////////////////////////
    // register storage

    // enable changes only in the update step
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_en_r <= LCC_CTRL_RESET[LCC_CTRL_EN_BIT];
        end else if (state_r == LCC_UPDATE) begin
            ctrl_en_r <= pend_en_r;
        end
    end

    // auxiliary write only when secure and cache disabled
    always_ff @(posedge core_clk) begin
        if (rst) begin
            auxiliary_config_reg_r <= LCC_AUX_RESET;
        end else if (aux_accept) begin
            auxiliary_config_reg_r <= req.wdata;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // answers

    // one-cycle answer, delayed for control writes until after update
    always_ff @(posedge core_clk) begin
        if (rst) begin
            resp_valid_r <= 1'b0;
            resp_code_r <= LCC_RESP_OKAY;
            resp_rdata_r <= 32'h0000_0000;
        end else if (state_r == LCC_UPDATE) begin
            resp_valid_r <= 1'b1;
            resp_code_r <= LCC_RESP_OKAY;
            resp_rdata_r <= 32'h0000_0000;
        end else if (take && !ctrl_accept) begin
            resp_valid_r <= 1'b1;
            resp_rdata_r <= 32'h0000_0000;
            resp_code_r <= LCC_RESP_OKAY;
            if (!(hit_type || hit_ctrl || hit_aux)) begin
                resp_code_r <= LCC_RESP_DECERR;
            end else if (!req.write) begin
                // reads open to secure and non-secure
                if (hit_type) begin
                    resp_rdata_r <= cache_type_info;
                end else if (hit_ctrl) begin
                    resp_rdata_r <= cache_main_control;
                end else begin
                    resp_rdata_r <= aux_view;
                end
            end else if (hit_ctrl) begin
                resp_code_r <= LCC_RESP_DECERR;
            end else if (hit_aux && !req.secure) begin
                resp_code_r <= LCC_RESP_DECERR;
            end else if (hit_aux && ctrl_en_r) begin
                resp_code_r <= LCC_RESP_SLVERR;
            end
        end else begin
            resp_valid_r <= 1'b0;
        end
    end

    assign resp.valid = resp_valid_r;
    assign resp.code = resp_code_r;
    assign resp.rdata = resp_rdata_r;

    //////////////////////////////////////////////////////////////////////////
    // configuration outputs

    assign cache_enable = ctrl_en_r;
    assign aux_config = aux_view;

    // capacity from the same fields the type register reports
    lcc_way_decode u_way_decode (
        .way_code(auxiliary_config_reg_r[LCC_AUX_WAY_HI:LCC_AUX_WAY_LO]),
        .assoc_sel(auxiliary_config_reg_r[LCC_AUX_ASSOC_BIT]),
        .way_kb(way_size_kb),
        .total_kb(cache_size_kb)
    );

endmodule : lcc_config_regs

// ---- test/lcc_drain_model.sv ----
`timescale 1ns/10ps
// cache drain stand-in answering a sync request after a set lag
module lcc_drain_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // drain handshake
    input wire logic sync_req,
    input wire logic [3:0] lag,
    output logic sync_done
);
    logic [3:0] wait_r;
    // count cycles of a pending sync; a slow drain holds done back
    always_ff @(posedge core_clk) begin
        if (rst || !sync_req) begin
            wait_r <= 4'h0;
        end else if (wait_r != 4'hf) begin
            wait_r <= wait_r + 4'h1;
        end
    end
    assign sync_done = sync_req && (wait_r >= lag);
endmodule : lcc_drain_model

// ---- test/lcc_cfg_monitor.sv ----
`timescale 1ns/10ps
// concurrent checks on the configuration register port
module lcc_cfg_monitor
    import lcc_pkg::*;
#(
    parameter bit LOCKDOWN_PER_MASTER_OPTION = 1'b0,
    parameter bit LOCKDOWN_PER_LINE_OPTION = 1'b0
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire lcc_req_s req,
    input wire logic req_ready,
    input wire lcc_resp_s resp,
    // drain handshake and configuration
    input wire logic ports_locked,
    input wire logic sync_req,
    input wire logic sync_done,
    input wire logic cache_enable,
    input wire logic [31:0] aux_config,
    input wire logic [9:0] way_size_kb,
    input wire logic [13:0] cache_size_kb
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // taken write and taken read strobes
    wire wr = req.valid && req_ready && req.write;
    wire rd = req.valid && req_ready && !req.write;
    wire [31:0] tv = {3'h0, 2'h3, LOCKDOWN_PER_MASTER_OPTION, LOCKDOWN_PER_LINE_OPTION, 2'h0,
        aux_config[19:17], 1'b0, aux_config[16], 7'h00, aux_config[19:17], 1'b0,
        aux_config[16], 6'h00};
    type_read_a: assert property (rd && req.addr == LCC_OFF_TYPE |=>
        resp.valid && resp.rdata == tv) else $error("type read value wrong");
    ns_ctrl_a: assert property (wr && !req.secure && req.addr == LCC_OFF_CTRL |=>
        resp.code == LCC_RESP_DECERR && $stable(cache_enable)) else $error("ns control write");
    aux_ns_a: assert property (wr && !req.secure && req.addr == LCC_OFF_AUX |=>
        resp.code == LCC_RESP_DECERR && $stable(aux_config)) else $error("ns aux write");
    aux_busy_a: assert property (wr && req.secure && cache_enable &&
        req.addr == LCC_OFF_AUX |=> resp.code == LCC_RESP_SLVERR && $stable(aux_config))
        else $error("aux write while on");
    lock_start_a: assert property (wr && req.secure && req.addr == LCC_OFF_CTRL |=>
        sync_req && ports_locked && !req_ready && !resp.valid) else $error("no drain");
    update_order_a: assert property ($changed(cache_enable) |->
        resp.valid && $past(ports_locked) && !$past(sync_req)) else $error("update order");
    answer_after_a: assert property (sync_req && sync_done |->
        ##2 resp.valid && resp.code == LCC_RESP_OKAY) else $error("late answer");
    ctrl_read_a: assert property (rd && req.addr == LCC_OFF_CTRL |=>
        resp.valid && resp.rdata == {31'h0, cache_enable}) else $error("control read");
    capacity_product_a: assert property (
        cache_size_kb == way_size_kb * (aux_config[16] ? 14'h10 : 14'h8))
        else $error("capacity product");
    en_cov: cover property (sync_req ##1 !sync_req ##1 cache_enable);
    slv_cov: cover property (resp.valid && resp.code == LCC_RESP_SLVERR);
    dec_cov: cover property (resp.valid && resp.code == LCC_RESP_DECERR);
endmodule : lcc_cfg_monitor
bind lcc_config_regs lcc_cfg_monitor #(
    .LOCKDOWN_PER_MASTER_OPTION(LOCKDOWN_PER_MASTER_OPTION),
    .LOCKDOWN_PER_LINE_OPTION(LOCKDOWN_PER_LINE_OPTION)
) lcc_cfg_monitor_inst (.core_clk, .rst, .req, .req_ready, .resp, .ports_locked, .sync_req,
    .sync_done, .cache_enable, .aux_config, .way_size_kb, .cache_size_kb);

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
// register bank bench: access tasks and directed tests
module tb_top
    import lcc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    lcc_req_s req = '0;
    lcc_resp_s resp;
    logic req_ready, ports_locked, sync_req, sync_done, cache_enable;
    logic [31:0] aux_config, rdata, ax;
    logic [9:0] way_size_kb;
    logic [13:0] cache_size_kb;
    logic [3:0] lag = 4'h0;
    logic [1:0] rcode;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    lcc_config_regs #(.LOCKDOWN_PER_MASTER_OPTION(1'b1)) lcc_config_regs_inst (.core_clk, .rst,
        .req, .req_ready, .resp, .ports_locked, .sync_req, .sync_done, .cache_enable,
        .aux_config, .way_size_kb, .cache_size_kb);
    lcc_drain_model lcc_drain_model_inst (.core_clk, .rst, .sync_req, .lag, .sync_done);
    always #20 core_clk = ~core_clk;
    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            $display("MISMATCH %0t timeout", $time);
            print_verdict();
        end
    end
    // expected type value, master lockdown built in
    function automatic logic [31:0] texp(input logic [31:0] a);
        return {5'h03, 2'h2, 2'h0, a[19:17], 1'b0, a[16], 7'h00, a[19:17], 1'b0, a[16], 6'h00};
    endfunction : texp
    function automatic logic [9:0] wkb(input logic [2:0] c);
        return (c == 3'h0) ? 10'h010 : (c == 3'h7) ? 10'h200 : 10'h010 << (c - 3'h1);
    endfunction : wkb
    // one access: hold until taken, then collect the answer
    task acc(input logic w, input logic s, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(negedge core_clk);
        req <= '{1'b1, w, s, a, d};
        for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge core_clk);
        @(negedge core_clk);
        req.valid <= 1'b0;
        for (i = 0; i < 50 && resp.valid !== 1'b1; i++) @(negedge core_clk);
        // an answer that never comes counts against the run
        if (resp.valid !== 1'b1) begin
            n_errors++;
            $display("MISMATCH %0t no answer", $time);
        end
        rcode = resp.code;
        rdata = resp.rdata;
    endtask : acc
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t word %h not %h", $time, got, exp);
        end
    endtask : chk_word
    task chk_code(input logic [1:0] exp);
        checks_done++;
        if (rcode !== exp) begin
            n_errors++;
            $display("MISMATCH %0t code %h not %h", $time, rcode, exp);
        end
    endtask : chk_code
    task print_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // directed sequence
    initial begin
        repeat (20) @(negedge core_clk);
        rst <= 1'b0;
        acc(1'b0, 1'b0, LCC_OFF_TYPE, 32'h0);
        chk_word(rdata, texp(LCC_AUX_RESET));
        acc(1'b0, 1'b0, LCC_OFF_CTRL, 32'h0);
        chk_word(rdata, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            ax = 32'h0200_0000 | {12'h0, i[3:0], 16'h0};
            acc(1'b1, 1'b1, LCC_OFF_AUX, ax ^ 32'h8200_0000);
            chk_code(LCC_RESP_OKAY);
            chk_word(aux_config, ax);
            acc(1'b0, 1'b1, LCC_OFF_TYPE, 32'h0);
            chk_word(rdata, texp(ax));
            chk_word({22'h0, way_size_kb}, {22'h0, wkb(i[3:1])});
            chk_word(32'(cache_size_kb), 32'(wkb(i[3:1])) * (i[0] ? 32'h10 : 32'h8));
        end
        $display("test way sizes done");
        acc(1'b1, 1'b1, LCC_OFF_TYPE, 32'hffff_ffff);
        chk_code(LCC_RESP_OKAY);
        acc(1'b0, 1'b0, LCC_OFF_TYPE, 32'h0);
        chk_word(rdata, texp(ax));
        acc(1'b1, 1'b0, LCC_OFF_CTRL, 32'h1);
        chk_code(LCC_RESP_DECERR);
        acc(1'b0, 1'b0, LCC_OFF_CTRL, 32'h0);
        chk_word(rdata, 32'h0);
        acc(1'b1, 1'b0, LCC_OFF_AUX, 32'h0);
        chk_code(LCC_RESP_DECERR);
        acc(1'b0, 1'b0, LCC_OFF_AUX, 32'h0);
        chk_word(rdata, ax);
        $display("test refusals done");
        lag <= 4'h5;
        acc(1'b1, 1'b1, LCC_OFF_CTRL, 32'hffff_ffff);
        chk_code(LCC_RESP_OKAY);
        chk_word({31'h0, cache_enable}, 32'h1);
        acc(1'b0, 1'b0, LCC_OFF_CTRL, 32'h0);
        chk_word(rdata, 32'h1);
        acc(1'b1, 1'b1, LCC_OFF_AUX, 32'h0);
        chk_code(LCC_RESP_SLVERR);
        acc(1'b1, 1'b0, LCC_OFF_AUX, 32'h0);
        chk_code(LCC_RESP_DECERR);
        chk_word(aux_config, ax);
        acc(1'b0, 1'b1, 12'h0f0, 32'h0);
        chk_code(LCC_RESP_DECERR);
        lag <= 4'h0;
        acc(1'b1, 1'b1, LCC_OFF_CTRL, 32'h0);
        chk_code(LCC_RESP_OKAY);
        acc(1'b0, 1'b1, LCC_OFF_CTRL, 32'h0);
        chk_word(rdata, 32'h0);
        $display("test enable done");
        print_verdict();
    end
endmodule : tb_top
